// [core/tsrm_regs.sv]
// User register bank of the tilt sensor behind its serial slave port.
// Assumes sensor readings and identity words arrive from core_clk_i logic;
// the serial pins are asynchronous and pass a two-stage synchroniser.
//
// Overview of operation
// - Acceleration x, y, z read-only words sit at 0x04, 0x06, 0x08.
// - Acceleration words are two's complement, one g per 16384 counts, zero is 0x0000.
// - Request word 0x0400 fetches the x acceleration word on the next frame.
// - Offset 0x00 reads the flash write counter, sixteen-bit unsigned, read-only.
// - Supply, temperature and three tilt words are read-only outputs.
// - Offset trims at 0x12, 0x14, 0x16 are readable and writable.
// - Alignment references at 0x18 to 0x1c are read-only to the host.
// - Alarm thresholds at 0x20 to 0x26 are readable and writable.
// - Alarm sample periods 0x28 to 0x2c and alarm control 0x2e are writable.
// - Operation words 0x32 to 0x3a are readable and writable.
// - System status at 0x3c is read-only.
// - System command at 0x3e is write-only and fires a command strobe.
// - Lot codes, product number and serial number are read-only.
// - Bias trims at 0x70, 0x72, 0x74 are readable and writable.
// - Reads take two frames; the answer shifts out during the second.
// - Writes carry one byte; even address low byte, odd address high byte.
`default_nettype none

module tsrm_regs
  import tsrm_pkg::*;
(
  input  wire logic                          core_clk_i,
  input  wire logic                          resetn_i,
  input  wire logic                          spi_cs_n_i,
  input  wire logic                          spi_sclk_i,
  input  wire logic                          spi_din_i,
  output logic                               spi_dout_o,
  output logic                               spi_dout_oe_n_o,
  input  wire logic [15:0]                   flash_count_i,
  input  wire logic [15:0]                   supply_i,
  input  wire logic [2:0][15:0]              accel_i,
  input  wire logic [15:0]                   temperature_i,
  input  wire logic [2:0][15:0]              tilt_i,
  input  wire logic [2:0][15:0]              align_ref_i,
  input  wire logic [15:0]                   status_i,
  input  wire logic [3:0][15:0]              ident_i,
  output logic [tsrm_pkg::CFG_N-1:0][15:0]   cfg_words_o,
  output logic                               cmd_strobe_o,
  output logic [15:0]                        cmd_word_o
);

  import tsrm_pkg::*;

  // ----------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------
  tsrm_state_type state_q;
  tsrm_state_type state_d;

  logic        sck_rise;
  logic        sck_fall;
  logic [15:0] frame;
  logic        is_write;
  logic [6:0]  addr;
  logic [6:0]  addr_even;
  logic [7:0]  wbyte;

  // ----------------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------------
  // Word-aligned lookup; byte address bit zero does not matter for reads
  function automatic logic [15:0] read_word(
    input logic [6:0]             a,
    input logic [CFG_N-1:0][15:0] cfg
  );
    logic [15:0] w;
    w = WORD_ZERO;
    unique case ({a[6:1], 1'b0})
      OFF_FLASH_WRITE_COUNTER: w = flash_count_i;
      OFF_SUPPLY:    w = supply_i;
      OFF_ACCEL_X:   w = accel_i[0];
      OFF_ACCEL_Y:   w = accel_i[1];
      OFF_ACCEL_Z:   w = accel_i[2];
      OFF_TEMP:      w = temperature_i;
      OFF_TILT_X:    w = tilt_i[0];
      OFF_TILT_Y:    w = tilt_i[1];
      OFF_TILT_Z:    w = tilt_i[2];
      OFF_X_TRIM:    w = cfg[0];
      OFF_Y_TRIM:    w = cfg[1];
      OFF_Z_TRIM:    w = cfg[2];
      OFF_X_ALIGN:   w = align_ref_i[0];
      OFF_Y_ALIGN:   w = align_ref_i[1];
      OFF_Z_ALIGN:   w = align_ref_i[2];
      OFF_X_ALM_THR: w = cfg[3];
      OFF_Y_ALM_THR: w = cfg[4];
      OFF_Z_ALM_THR: w = cfg[5];
      OFF_S_ALM_THR: w = cfg[6];
      OFF_X_ALM_PER: w = cfg[7];
      OFF_Y_ALM_PER: w = cfg[8];
      OFF_Z_ALM_PER: w = cfg[9];
      OFF_ALARM_CONTROL:  w = cfg[10];
      OFF_GPIO_CFG:  w = cfg[11];
      OFF_ORIENT:    w = cfg[12];
      OFF_DPIN_CFG:  w = cfg[13];
      OFF_DECIM:     w = cfg[14];
      OFF_SLEEP:     w = cfg[15];
      OFF_STATUS:    w = status_i;
      OFF_COMMAND:   w = WORD_ZERO;
      OFF_LOT_A:     w = ident_i[0];
      OFF_LOT_B:     w = ident_i[1];
      OFF_PRODUCT:   w = ident_i[2];
      OFF_SERIAL:    w = ident_i[3];
      OFF_X_BIAS:    w = cfg[16];
      OFF_Y_BIAS:    w = cfg[17];
      OFF_Z_BIAS:    w = cfg[18];
      default:       w = WORD_ZERO;
    endcase
    return w;
  endfunction : read_word

  // ----------------------------------------------------------------------
  // Frame decode helpers
  // ----------------------------------------------------------------------
  // Edges come from the second synchroniser stage and its delayed copy only
  assign sck_rise  = state_q.sck_sync & ~state_q.sck_last;
  assign sck_fall  = ~state_q.sck_sync & state_q.sck_last;
  assign frame     = {state_q.rx_shift[14:0], state_q.din_sync};
  assign is_write  = frame[RW_BIT];
  assign addr      = frame[ADDR_HI:ADDR_LO];
  assign addr_even = {addr[6:1], 1'b0};
  assign wbyte     = frame[7:0];

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    state_d = state_q;

    // Synchronisers: first stage feeds only the second
    state_d.cs_meta  = spi_cs_n_i;
    state_d.cs_sync  = state_q.cs_meta;
    state_d.sck_meta = spi_sclk_i;
    state_d.sck_sync = state_q.sck_meta;
    state_d.sck_last = state_q.sck_sync;
    state_d.din_meta = spi_din_i;
    state_d.din_sync = state_q.din_meta;

    state_d.cmd_stb   = 1'b0;
    state_d.dout_oe_n = state_q.cs_sync;

    if (state_q.cs_sync) begin
      // Deselected: drop partial frame, keep any pending answer
      state_d.bit_cnt = 4'h0;
      state_d.dout    = state_q.tx_shift[15];
    end else begin
      // Mode three: shift out on falling, sample on rising
      if (sck_fall) begin
        state_d.dout     = state_q.tx_shift[15];
        state_d.tx_shift = {state_q.tx_shift[14:0], 1'b0};
      end
      if (sck_rise) begin
        state_d.rx_shift = frame;
        if (state_q.bit_cnt == LAST_BIT) begin
          state_d.bit_cnt = 4'h0;
          if (!is_write) begin
            // Answer goes out during the following frame
            state_d.tx_shift = read_word(addr, state_q.cfg);
          end else begin
            // A write frame leaves nothing to answer next time
            state_d.tx_shift = WORD_ZERO;
            for (int i = 0; i < CFG_N; i++) begin
              if (addr_even == CFG_OFFSET[i]) begin
                if (addr[0]) begin
                  state_d.cfg[i][15:8] = wbyte;
                end else begin
                  state_d.cfg[i][7:0] = wbyte;
                end
              end
            end
            if (addr_even == OFF_COMMAND) begin
              state_d.cmd_stb = 1'b1;
              if (addr[0]) begin
                state_d.cmd_word[15:8] = wbyte;
              end else begin
                state_d.cmd_word[7:0] = wbyte;
              end
            end
            // Read-only, reserved and unmapped words take no write
          end
        end else begin
          state_d.bit_cnt = state_q.bit_cnt + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q.cs_meta   <= 1'b1;
      state_q.cs_sync   <= 1'b1;
      state_q.sck_meta  <= 1'b1;
      state_q.sck_sync  <= 1'b1;
      state_q.sck_last  <= 1'b1;
      state_q.din_meta  <= 1'b0;
      state_q.din_sync  <= 1'b0;
      state_q.bit_cnt   <= 4'h0;
      state_q.rx_shift  <= WORD_ZERO;
      state_q.tx_shift  <= WORD_ZERO;
      state_q.dout      <= 1'b0;
      state_q.dout_oe_n <= 1'b1;
      state_q.cfg       <= {CFG_N{CFG_RESET}};
      state_q.cmd_stb   <= 1'b0;
      state_q.cmd_word  <= WORD_ZERO;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Readings pass straight through; scaling stays with the sensor path
  assign spi_dout_o      = state_q.dout;
  assign spi_dout_oe_n_o = state_q.dout_oe_n;
  assign cfg_words_o     = state_q.cfg;
  assign cmd_strobe_o    = state_q.cmd_stb;
  assign cmd_word_o      = state_q.cmd_word;

endmodule : tsrm_regs

`default_nettype wire

// [core/tsrm_pkg.sv]
// Constants, offsets and state type of the tilt sensor user register bank.
// Assumes a serial mode-3 host and 7-bit byte addresses in the request word.
`default_nettype none

package tsrm_pkg;

  // ----------------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------------
  localparam int          WORD_W       = 16;
  localparam logic [3:0]  LAST_BIT     = 4'hf;
  localparam int          RW_BIT       = 15;
  localparam int          ADDR_HI      = 14;
  localparam int          ADDR_LO      = 8;
  localparam logic [15:0] WORD_ZERO    = 16'h0000;
  localparam logic [15:0] CFG_RESET    = 16'h0000;

  // ----------------------------------------------------------------------
  // Byte offsets
  // ----------------------------------------------------------------------
  localparam logic [6:0] OFF_FLASH_WRITE_COUNTER  = 7'h00;
  localparam logic [6:0] OFF_SUPPLY     = 7'h02;
  localparam logic [6:0] OFF_ACCEL_X    = 7'h04;
  localparam logic [6:0] OFF_ACCEL_Y    = 7'h06;
  localparam logic [6:0] OFF_ACCEL_Z    = 7'h08;
  localparam logic [6:0] OFF_TEMP       = 7'h0a;
  localparam logic [6:0] OFF_TILT_X     = 7'h0c;
  localparam logic [6:0] OFF_TILT_Y     = 7'h0e;
  localparam logic [6:0] OFF_TILT_Z     = 7'h10;
  localparam logic [6:0] OFF_X_TRIM     = 7'h12;
  localparam logic [6:0] OFF_Y_TRIM     = 7'h14;
  localparam logic [6:0] OFF_Z_TRIM     = 7'h16;
  localparam logic [6:0] OFF_X_ALIGN    = 7'h18;
  localparam logic [6:0] OFF_Y_ALIGN    = 7'h1a;
  localparam logic [6:0] OFF_Z_ALIGN    = 7'h1c;
  localparam logic [6:0] OFF_X_ALM_THR  = 7'h20;
  localparam logic [6:0] OFF_Y_ALM_THR  = 7'h22;
  localparam logic [6:0] OFF_Z_ALM_THR  = 7'h24;
  localparam logic [6:0] OFF_S_ALM_THR  = 7'h26;
  localparam logic [6:0] OFF_X_ALM_PER  = 7'h28;
  localparam logic [6:0] OFF_Y_ALM_PER  = 7'h2a;
  localparam logic [6:0] OFF_Z_ALM_PER  = 7'h2c;
  localparam logic [6:0] OFF_ALARM_CONTROL   = 7'h2e;
  localparam logic [6:0] OFF_GPIO_CFG   = 7'h32;
  localparam logic [6:0] OFF_ORIENT     = 7'h34;
  localparam logic [6:0] OFF_DPIN_CFG   = 7'h36;
  localparam logic [6:0] OFF_DECIM      = 7'h38;
  localparam logic [6:0] OFF_SLEEP      = 7'h3a;
  localparam logic [6:0] OFF_STATUS     = 7'h3c;
  localparam logic [6:0] OFF_COMMAND    = 7'h3e;
  localparam logic [6:0] OFF_LOT_A      = 7'h52;
  localparam logic [6:0] OFF_LOT_B      = 7'h54;
  localparam logic [6:0] OFF_PRODUCT    = 7'h56;
  localparam logic [6:0] OFF_SERIAL     = 7'h58;
  localparam logic [6:0] OFF_X_BIAS     = 7'h70;
  localparam logic [6:0] OFF_Y_BIAS     = 7'h72;
  localparam logic [6:0] OFF_Z_BIAS     = 7'h74;

  // ----------------------------------------------------------------------
  // Writable slots, in output order
  // ----------------------------------------------------------------------
  localparam int CFG_N = 19;
  localparam logic [6:0] CFG_OFFSET [CFG_N] = '{
    OFF_X_TRIM, OFF_Y_TRIM, OFF_Z_TRIM,
    OFF_X_ALM_THR, OFF_Y_ALM_THR, OFF_Z_ALM_THR, OFF_S_ALM_THR,
    OFF_X_ALM_PER, OFF_Y_ALM_PER, OFF_Z_ALM_PER, OFF_ALARM_CONTROL,
    OFF_GPIO_CFG, OFF_ORIENT, OFF_DPIN_CFG, OFF_DECIM, OFF_SLEEP,
    OFF_X_BIAS, OFF_Y_BIAS, OFF_Z_BIAS
  };

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic                    cs_meta;
    logic                    cs_sync;
    logic                    sck_meta;
    logic                    sck_sync;
    logic                    sck_last;
    logic                    din_meta;
    logic                    din_sync;
    logic [3:0]              bit_cnt;
    logic [15:0]             rx_shift;
    logic [15:0]             tx_shift;
    logic                    dout;
    logic                    dout_oe_n;
    logic [CFG_N-1:0][15:0]  cfg;
    logic                    cmd_stb;
    logic [15:0]             cmd_word;
  } tsrm_state_type;

endpackage : tsrm_pkg

`default_nettype wire

// [tb/tsrm_asserts.sv]
// Port-level checks on the tilt sensor register bank.
// Assumes one core clock domain and a fixed two-stage synchroniser latency.
`default_nettype none

module tsrm_asserts
  import tsrm_pkg::*;
(
  input wire logic                             core_clk_i,
  input wire logic                             resetn_i,
  input wire logic                             spi_cs_n_i,
  input wire logic                             spi_sclk_i,
  input wire logic                             spi_dout_oe_n_o,
  input wire logic [tsrm_pkg::CFG_N-1:0][15:0] cfg_words_o,
  input wire logic                             cmd_strobe_o,
  input wire logic [15:0]                      cmd_word_o
);
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  // Five cycles cover the two-stage synchroniser plus the output register
  sequence cs_held; !spi_cs_n_i [*5]; endsequence
  sequence cs_idle; spi_cs_n_i [*5]; endsequence

  oe_on_a: assert property (cs_held |-> !spi_dout_oe_n_o)
    else $error("data out not driven while selected");
  oe_off_a: assert property (cs_idle |-> spi_dout_oe_n_o)
    else $error("data out driven while deselected");
  strobe_single_a: assert property (cmd_strobe_o |=> !cmd_strobe_o)
    else $error("command strobe longer than one cycle");
  cmd_hold_a: assert property ($changed(cmd_word_o) |-> cmd_strobe_o)
    else $error("command word changed without strobe");
  strobe_cause_a: assert property (cmd_strobe_o |-> $past(!spi_cs_n_i, 4))
    else $error("command strobe outside a frame");
  cfg_cause_a: assert property ($changed(cfg_words_o) |->
    $past(!spi_cs_n_i, 3) && $past(spi_sclk_i, 3))
    else $error("config changed outside a write frame");
  cmd_apart_a: assert property (cmd_strobe_o |-> $stable(cfg_words_o))
    else $error("command write altered config");
  reset_clear_a: assert property ($rose(resetn_i) |->
    cfg_words_o == {CFG_N{CFG_RESET}} && !cmd_strobe_o)
    else $error("outputs not cleared by reset");
endmodule : tsrm_asserts

bind tsrm_regs tsrm_asserts tsrm_asserts_inst (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .spi_cs_n_i(spi_cs_n_i),
  .spi_sclk_i(spi_sclk_i), .spi_dout_oe_n_o(spi_dout_oe_n_o),
  .cfg_words_o(cfg_words_o), .cmd_strobe_o(cmd_strobe_o), .cmd_word_o(cmd_word_o));

`default_nettype wire

// [tb/tsrm_host.sv]
// Serial host model driving frames into the register bank.
// Assumes the bench resolves the data-out wire and one caller at a time.
`default_nettype none

module tsrm_host (
  input  wire logic core_clk_i,
  input  wire logic miso_i,
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      mosi_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------------
  // Frame engine
  // ----------------------------------------------------------------------
  // Link clock of 125 ns runs free of the core clock; non-blocking updates
  // keep a pin change that meets a core edge from racing its sampling
  localparam realtime HALF_NS = 62.5;

  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b1;
    mosi_o = 1'b0;
  end

  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    if (tx[15] && tx[14:9] == 6'h0f) tx = 16'h0000;
    @(posedge core_clk_i);
    cs_n_o <= 1'b0;
    #(HALF_NS);
    for (int i = 15; i >= 0; i--) begin
      sclk_o <= 1'b0;
      mosi_o <= tx[i];
      #(HALF_NS);
      rx[i] = miso_i;
      sclk_o <= 1'b1;
      #(HALF_NS);
    end
    cs_n_o <= 1'b1;
    mosi_o <= ~mosi_o;
    #(HALF_NS);
  endtask : xfer
endmodule : tsrm_host

`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the tilt sensor register bank.
// Assumes the host model and checker files are compiled before it.
`default_nettype none

module testbench import tsrm_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------------
  // Stimulus and checks
  // ----------------------------------------------------------------------
  localparam logic [16:0][6:0] RO_OFF = {7'h58, 7'h56, 7'h54, 7'h52, 7'h3c, 7'h1c,
    7'h1a, 7'h18, 7'h10, 7'h0e, 7'h0c, 7'h0a, 7'h08, 7'h06, 7'h04, 7'h02, 7'h00};
  localparam logic [16:0][15:0] RV = {16'ha758, 16'ha956, 16'hab54, 16'had52, 16'hc33c,
    16'he31c, 16'he51a, 16'he718, 16'hef10, 16'hf10e, 16'hf30c, 16'h04fe, 16'h0000,
    16'hc000, 16'h6ccd, 16'h547b, 16'hff00};
  logic clk, rst_n, cs_n, sclk, din, dout, oe_n, miso, strobe;
  logic [15:0] flash_write_counter, supply, temp, status, cmd_word;
  logic [2:0][15:0] accel, tilt, align;
  logic [3:0][15:0] ident;
  logic [CFG_N-1:0][15:0] cfg;
  int errors = 0, samples_checked = 0, strobes = 0;
  // Released line shows the inverse so a stale bit cannot pass
  assign miso = oe_n ? ~dout : dout;

  tsrm_regs tsrm_regs_inst (.core_clk_i(clk), .resetn_i(rst_n), .spi_cs_n_i(cs_n),
    .spi_sclk_i(sclk), .spi_din_i(din), .spi_dout_o(dout), .spi_dout_oe_n_o(oe_n),
    .flash_count_i(flash_write_counter), .supply_i(supply), .accel_i(accel),
    .temperature_i(temp), .tilt_i(tilt), .align_ref_i(align), .status_i(status),
    .ident_i(ident), .cfg_words_o(cfg), .cmd_strobe_o(strobe), .cmd_word_o(cmd_word));
  tsrm_host tsrm_host_inst (.core_clk_i(clk), .miso_i(miso), .cs_n_o(cs_n),
    .sclk_o(sclk), .mosi_o(din));

  always @(posedge clk) if (strobe === 1'b1) strobes <= strobes + 1;

  task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp16

  task automatic rd(input logic [6:0] a, output logic [15:0] v);
    logic [15:0] junk;
    tsrm_host_inst.xfer({1'b0, a, 8'h00}, junk);
    tsrm_host_inst.xfer(16'h0000, v);
  endtask : rd

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] junk;
    tsrm_host_inst.xfer({1'b1, a, d}, junk);
  endtask : wr

  task automatic t_reset;
    for (int k = 0; k < CFG_N; k++) cmp16("cfg reset", CFG_RESET, cfg[k]);
    cmp16("cmd word reset", WORD_ZERO, cmd_word);
    cmp16("dout enable", 16'h0001, {15'h0000, oe_n});
    $display("t_reset done");
  endtask : t_reset

  task automatic t_accel;
    logic [15:0] v;
    tsrm_host_inst.xfer(16'h0400, v);
    tsrm_host_inst.xfer(16'h0600, v);
    cmp16("accel x", RV[2], v);
    tsrm_host_inst.xfer(16'h0800, v);
    cmp16("accel y", RV[3], v);
    tsrm_host_inst.xfer(16'h0000, v);
    cmp16("accel z", RV[4], v);
    $display("t_accel done");
  endtask : t_accel

  task automatic t_ro;
    logic [15:0] v;
    for (int k = 0; k < 17; k++) begin
      rd(RO_OFF[k], v);
      cmp16("ro read", RV[k], v);
    end
    wr(7'h18, 8'h5a);
    wr(7'h05, 8'h5a);
    rd(7'h18, v);
    cmp16("align after write", RV[9], v);
    rd(7'h04, v);
    cmp16("accel after write", RV[2], v);
    $display("t_ro done");
  endtask : t_ro

  task automatic t_rw;
    logic [15:0] v;
    for (int k = 0; k < CFG_N; k++) begin
      wr(CFG_OFFSET[k], 8'(k + 1));
      wr(CFG_OFFSET[k] | 7'h01, 8'(k + 128));
    end
    for (int k = 0; k < CFG_N; k++) begin
      rd(CFG_OFFSET[k], v);
      cmp16("rw read", {8'(k + 128), 8'(k + 1)}, v);
      cmp16("cfg out", {8'(k + 128), 8'(k + 1)}, cfg[k]);
    end
    $display("t_rw done");
  endtask : t_rw

  task automatic t_cmd;
    logic [15:0] v;
    int s0;
    s0 = strobes;
    wr(7'h3e, 8'h5a);
    wr(7'h3f, 8'ha5);
    cmp16("strobe count", 16'h0002, 16'(strobes - s0));
    cmp16("cmd word", 16'ha55a, cmd_word);
    rd(7'h3e, v);
    cmp16("cmd read", WORD_ZERO, v);
    cmp16("cfg slot 14", 16'h8e0f, cfg[14]);
    $display("t_cmd done");
  endtask : t_cmd

  task automatic t_unmapped;
    logic [15:0] v;
    wr(7'h30, 8'h11);
    wr(7'h40, 8'h22);
    wr(7'h6f, 8'h33);
    rd(7'h1e, v);
    cmp16("reserved read", WORD_ZERO, v);
    rd(7'h44, v);
    cmp16("unmapped read", WORD_ZERO, v);
    for (int k = 0; k < CFG_N; k++) cmp16("cfg kept", {8'(k + 128), 8'(k + 1)}, cfg[k]);
    $display("t_unmapped done");
  endtask : t_unmapped

  task automatic complete_run;
    $display("Counts: %0d compared, %0d mismatched", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    $display("ERROR run length expected finish seen timeout");
    complete_run;
  end

  initial begin
    rst_n = 1'b0;
    {ident, status, align, tilt, temp, accel, supply, flash_write_counter} = RV;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset;
    t_accel;
    t_ro;
    t_rw;
    t_cmd;
    t_unmapped;
    complete_run;
  end
endmodule : testbench

`default_nettype wire
